// [hsw_pkg.sv]
// Package with constants for the host serial write and power command decoder
package hsw_pkg;
   localparam int addr_width = 22;
   localparam int byte_width = 8;
   localparam int fifo_depth = 32;
   localparam int word_width = addr_width + byte_width;
   // Prefix values in bits 7..6 of the first byte
   localparam logic [1:0] prefix_write = 2'h2;
   localparam logic [1:0] prefix_command = 2'h1;
   localparam logic [1:0] prefix_read = 2'h0;
   localparam int prefix_msb = 7;
   localparam int prefix_lsb = 6;
   localparam int addr_hi_bits = 6;
   // Command codes, first byte including bits 7..6
   localparam logic [7:0] active_cmd = 8'h00;
   localparam logic [7:0] standby_cmd = 8'h41;
   localparam logic [7:0] sleep_cmd = 8'h42;
   localparam logic [7:0] regulator_off_cmd = 8'h50;
   localparam logic [7:0] external_ref_cmd = 8'h44;
   localparam logic [7:0] pll_high_freq_cmd = 8'h62;
   localparam logic [7:0] pll_low_freq_cmd = 8'h61;
   localparam logic [7:0] core_reset_cmd = 8'h68;
   // Address regions
   localparam logic [21:0] identity_rom_base = 22'h0c_0000;
   localparam logic [21:0] identity_rom_last = 22'h0c_0003;
   localparam logic [21:0] cmd_buffer_base = 22'h10_8000;
   localparam logic [21:0] cmd_buffer_last = 22'h10_8fff;
   localparam logic [21:0] reg_base = 22'h10_2400;
   localparam logic [21:0] reg_last = 22'h10_257f;
   // Identity bytes; values arbitrary
   localparam logic [15:0] chip_identity = 16'h1234;
   localparam logic [15:0] chip_revision = 16'h0001;
   // Core reset pulse length in clock cycles
   localparam int core_reset_cycles = 4;
   localparam logic [2:0] core_reset_count = 3'(core_reset_cycles);
   // Power states
   typedef enum logic [1:0] {pwr_active, pwr_standby, pwr_sleep, pwr_off} power_type;
   // Reset values
   localparam logic [21:0] addr_reset = 22'h00_0000;
   localparam logic [7:0] byte_reset = 8'h00;
endpackage : hsw_pkg

// [hsw_fifo.sv]
// Write-word FIFO with parameterised width and depth
`timescale 1ns/10ps
module hsw_fifo #(
   parameter int width = 30,
   parameter int depth = 32
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [width-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [width-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int aw = $clog2(depth);
   logic [width-1:0] mem [depth];
   logic [aw-1:0] wr_q;
   logic [aw-1:0] rd_q;
   logic [aw:0] count_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Honest full and empty from the occupancy count
   assign in_ready = (count_q != (aw+1)'(depth));
   assign out_valid = (count_q != '0);
   assign out_data = mem[rd_q];

   // Pointers and count
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= aw'((wr_q + 1'b1) % depth);
         if (pop)
            rd_q <= aw'((rd_q + 1'b1) % depth);
         count_q <= count_q + (aw+1)'(push) - (aw+1)'(pop);
      end
   end

   // Storage
   always_ff @(posedge clock)
   begin
      if (push)
         mem[wr_q] <= in_data;
   end

   // Occupancy never passes the depth, so a push when full is caught
   property p_no_overflow;
      @(posedge clock) disable iff (!rst_n)
      count_q <= (aw+1)'(depth);
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("fifo occupancy above depth");
endmodule : hsw_fifo

// [hsw_spi_rx.sv]
// SPI mode 0 receiver that delivers bytes and frame boundaries
`timescale 1ns/10ps
module hsw_spi_rx (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic ss_n,
   output logic [7:0] rx_byte,
   output logic rx_strobe,
   output logic frame_start,
   output logic frame_end,
   output logic in_frame
);
   logic [2:0] sck_s_q;
   logic [2:0] mosi_s_q;
   logic [2:0] ss_s_q;
   logic [7:0] shift_q;
   logic [2:0] bit_q;
   logic strobe_q;
   logic start_q;
   logic end_q;

   // Stage 0 feeds stage 1 only; edges use stages 1 and 2
   wire sck_rise = sck_s_q[1] && !sck_s_q[2];
   wire sel = !ss_s_q[1];
   wire sel_fall = !ss_s_q[1] && ss_s_q[2];
   wire sel_rise = ss_s_q[1] && !ss_s_q[2];
   wire [7:0] shift_next = {shift_q[6:0], mosi_s_q[2]};

   assign rx_byte = shift_q;
   assign rx_strobe = strobe_q;
   assign frame_start = start_q;
   assign frame_end = end_q;
   assign in_frame = sel;

   // Synchronisers; data is delayed one more stage to line up with the edge
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         sck_s_q <= 3'h0;
         mosi_s_q <= 3'h0;
         ss_s_q <= 3'h7;
      end
      else
      begin
         sck_s_q <= {sck_s_q[1:0], sck};
         mosi_s_q <= {mosi_s_q[1:0], mosi};
         ss_s_q <= {ss_s_q[1:0], ss_n};
      end
   end

   // Sample on rising edge, most significant bit first
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         shift_q <= 8'h00;
         bit_q <= 3'h0;
         strobe_q <= 1'b0;
         start_q <= 1'b0;
         end_q <= 1'b0;
      end
      else
      begin
         strobe_q <= 1'b0;
         start_q <= sel_fall;
         end_q <= sel_rise;
         if (!sel)
            bit_q <= 3'h0;
         else if (sck_rise)
         begin
            shift_q <= shift_next;
            bit_q <= bit_q + 3'h1;
            strobe_q <= (bit_q == 3'h7);
         end
      end
   end
endmodule : hsw_spi_rx

// [hsw_decoder.sv]
// Host serial transaction decoder: memory writes and power commands
`timescale 1ns/10ps
module hsw_decoder (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic spi_sck,
   input wire logic spi_mosi,
   input wire logic spi_ss_n,
   output logic [21:0] wr_addr,
   output logic [7:0] wr_data,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic wr_in_cmd_buffer,
   output logic wr_to_register,
   output logic wr_to_rom,
   output logic overflow,
   output logic core_clock_en,
   output logic pll_on,
   output logic osc_on,
   output logic regulator_on,
   output logic ext_ref_sel,
   output logic pll_high_freq,
   output logic core_reset,
   output logic [31:0] identity_word
);
   typedef enum logic [2:0] {st_idle, st_addr1, st_addr2, st_data, st_cmd1, st_cmd2,
      st_skip} frame_type;

   logic [7:0] rx_byte;
   logic rx_strobe;
   logic frame_start;
   logic frame_end;
   logic in_frame;
   logic fifo_in_ready;
   logic [29:0] fifo_out_data;
   logic fifo_out_valid;

   frame_type state_q;
   frame_type state_d;
   logic [21:0] addr_q;
   logic [21:0] addr_d;
   logic [7:0] cmd_q;
   logic cmd_zero_q;
   logic cmd_fire_q;
   hsw_pkg::power_type power_q;
   logic ext_ref_q;
   logic high_freq_q;
   logic [2:0] rst_cnt_q;
   logic overflow_q;
   logic [21:0] wr_addr_q;
   logic [7:0] wr_data_q;
   logic wr_valid_q;
   logic cmd_buf_q;
   logic reg_q;
   logic rom_q;
   logic clk_en_q;
   logic pll_q;
   logic osc_q;
   logic reg_on_q;
   logic core_rst_q;

   // Address region checks, used for each output word
   function automatic logic in_range(input logic [21:0] a, input logic [21:0] lo,
      input logic [21:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   hsw_spi_rx i_hsw_spi_rx (
      .clock(clock),
      .rst_n(rst_n),
      .sck(spi_sck),
      .mosi(spi_mosi),
      .ss_n(spi_ss_n),
      .rx_byte(rx_byte),
      .rx_strobe(rx_strobe),
      .frame_start(frame_start),
      .frame_end(frame_end),
      .in_frame(in_frame)
   );

   // Byte prefix decode
   wire [1:0] prefix = rx_byte[hsw_pkg::prefix_msb:hsw_pkg::prefix_lsb];
   wire is_write = (prefix == hsw_pkg::prefix_write);
   wire is_command = (prefix == hsw_pkg::prefix_command) || (rx_byte == hsw_pkg::active_cmd);
   wire data_byte = rx_strobe && (state_q == st_data);
   wire push = data_byte && fifo_in_ready;
   wire [29:0] fifo_in_data = {addr_q, rx_byte};
   wire cmd_done = rx_strobe && (state_q == st_cmd2) && cmd_zero_q && (rx_byte == 8'h00);
   wire out_take = !wr_valid_q || wr_ready;
   wire [21:0] out_addr = fifo_out_data[29:8];

   // Frame state and address sequencing
   always_comb
   begin
      state_d = state_q;
      addr_d = addr_q;
      if (frame_start || frame_end)
         state_d = st_idle;
      else if (rx_strobe)
      begin
         case (state_q)
            st_idle:
            begin
               if (is_write)
               begin
                  state_d = st_addr1;
                  addr_d = {rx_byte[hsw_pkg::addr_hi_bits-1:0], 16'h0000};
               end
               else if (is_command)
                  state_d = st_cmd1;
               else
                  state_d = st_skip;
            end
            st_addr1:
            begin
               state_d = st_addr2;
               addr_d = {addr_q[21:16], rx_byte, addr_q[7:0]};
            end
            st_addr2:
            begin
               state_d = st_data;
               addr_d = {addr_q[21:8], rx_byte};
            end
            st_data:
               addr_d = addr_q + 22'h00_0001;
            st_cmd1:
               state_d = st_cmd2;
            st_cmd2:
               state_d = st_skip;
            st_skip:
               state_d = st_skip;
            default:
               state_d = st_idle;
         endcase
      end
   end

   // Frame registers and command capture
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_q <= st_idle;
         addr_q <= hsw_pkg::addr_reset;
         cmd_q <= hsw_pkg::byte_reset;
         cmd_zero_q <= 1'b0;
         cmd_fire_q <= 1'b0;
         overflow_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         addr_q <= addr_d;
         if (rx_strobe && state_q == st_idle)
            cmd_q <= rx_byte;
         if (rx_strobe && state_q == st_cmd1)
            cmd_zero_q <= (rx_byte == 8'h00);
         cmd_fire_q <= cmd_done && !frame_end;
         if (data_byte && !fifo_in_ready)
            overflow_q <= 1'b1;
      end
   end

   hsw_fifo #(
      .width(hsw_pkg::word_width),
      .depth(hsw_pkg::fifo_depth)
   ) i_hsw_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_data(fifo_in_data),
      .in_valid(data_byte),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(out_take)
   );

   // Output word register, with region flags
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         wr_addr_q <= hsw_pkg::addr_reset;
         wr_data_q <= hsw_pkg::byte_reset;
         wr_valid_q <= 1'b0;
         cmd_buf_q <= 1'b0;
         reg_q <= 1'b0;
         rom_q <= 1'b0;
      end
      else if (out_take)
      begin
         wr_valid_q <= fifo_out_valid;
         wr_addr_q <= out_addr;
         wr_data_q <= fifo_out_data[7:0];
         cmd_buf_q <= in_range(out_addr, hsw_pkg::cmd_buffer_base,
            hsw_pkg::cmd_buffer_last);
         reg_q <= in_range(out_addr, hsw_pkg::reg_base, hsw_pkg::reg_last);
         rom_q <= in_range(out_addr, hsw_pkg::identity_rom_base,
            hsw_pkg::identity_rom_last);
      end
   end

   // Power and clock control from completed commands
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         power_q <= hsw_pkg::pwr_standby;
         ext_ref_q <= 1'b0;
         high_freq_q <= 1'b1;
         rst_cnt_q <= 3'h0;
      end
      else
      begin
         if (rst_cnt_q != 3'h0)
            rst_cnt_q <= rst_cnt_q - 3'h1;
         if (cmd_fire_q)
         begin
            case (cmd_q)
               hsw_pkg::active_cmd: power_q <= hsw_pkg::pwr_active;
               hsw_pkg::standby_cmd: power_q <= hsw_pkg::pwr_standby;
               hsw_pkg::sleep_cmd: power_q <= hsw_pkg::pwr_sleep;
               hsw_pkg::regulator_off_cmd: power_q <= hsw_pkg::pwr_off;
               hsw_pkg::external_ref_cmd: ext_ref_q <= 1'b1;
               hsw_pkg::pll_high_freq_cmd: high_freq_q <= 1'b1;
               hsw_pkg::pll_low_freq_cmd: high_freq_q <= 1'b0;
               hsw_pkg::core_reset_cmd: rst_cnt_q <= hsw_pkg::core_reset_count;
               default: power_q <= power_q;
            endcase
         end
      end
   end

   // Registered power-domain outputs
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         clk_en_q <= 1'b0;
         pll_q <= 1'b1;
         osc_q <= 1'b1;
         reg_on_q <= 1'b1;
         core_rst_q <= 1'b0;
      end
      else
      begin
         clk_en_q <= (power_q == hsw_pkg::pwr_active);
         pll_q <= (power_q == hsw_pkg::pwr_active) || (power_q == hsw_pkg::pwr_standby);
         osc_q <= (power_q == hsw_pkg::pwr_active) || (power_q == hsw_pkg::pwr_standby);
         reg_on_q <= (power_q != hsw_pkg::pwr_off);
         core_rst_q <= (rst_cnt_q != 3'h0);
      end
   end

   assign wr_addr = wr_addr_q;
   assign wr_data = wr_data_q;
   assign wr_valid = wr_valid_q;
   assign wr_in_cmd_buffer = cmd_buf_q;
   assign wr_to_register = reg_q;
   assign wr_to_rom = rom_q;
   assign overflow = overflow_q;
   assign core_clock_en = clk_en_q;
   assign pll_on = pll_q;
   assign osc_on = osc_q;
   assign regulator_on = reg_on_q;
   assign ext_ref_sel = ext_ref_q;
   assign pll_high_freq = high_freq_q;
   assign core_reset = core_rst_q;
   // Identity word, byte 0 least significant
   assign identity_word = {hsw_pkg::chip_revision, hsw_pkg::chip_identity};

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_write_prefix;
      rx_strobe && state_q == st_idle && is_write && !frame_end |=> state_q == st_addr1;
   endproperty
   a_write_prefix: assert property (p_write_prefix) else $error("write prefix missed");
   property p_addr_inc;
      data_byte && !frame_start && !frame_end |=> addr_q == $past(addr_q) + 22'h00_0001;
   endproperty
   a_addr_inc: assert property (p_addr_inc) else $error("address did not advance");
   property p_cmd_full;
      cmd_fire_q |-> $past(state_q) == st_cmd2;
   endproperty
   a_cmd_full: assert property (p_cmd_full) else $error("command fired early");
   property p_wake;
      cmd_fire_q && cmd_q == hsw_pkg::active_cmd |=> ##1 core_clock_en;
   endproperty
   a_wake: assert property (p_wake) else $error("wake did not enable clock");
   property p_sleep;
      cmd_fire_q && cmd_q == hsw_pkg::sleep_cmd |=> ##1 !pll_on && !osc_on && !core_clock_en;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep left clocks on");
   property p_standby;
      cmd_fire_q && cmd_q == hsw_pkg::standby_cmd |=> ##1 pll_on && osc_on && !core_clock_en;
   endproperty
   a_standby: assert property (p_standby) else $error("standby state wrong");
   property p_off;
      cmd_fire_q && cmd_q == hsw_pkg::regulator_off_cmd |=> ##1 !regulator_on && !pll_on;
   endproperty
   a_off: assert property (p_off) else $error("regulator still on");
   property p_low;
      cmd_fire_q && cmd_q == hsw_pkg::pll_low_freq_cmd |=> !pll_high_freq;
   endproperty
   a_low: assert property (p_low) else $error("36MHz not selected");
   property p_core_rst;
      cmd_fire_q && cmd_q == hsw_pkg::core_reset_cmd |=> ##1 core_reset[*4] ##1 !core_reset;
   endproperty
   a_core_rst: assert property (p_core_rst) else $error("core reset pulse wrong");
   c_write: cover property (@(posedge clock) disable iff (!rst_n) push ##[1:40] wr_valid);
   c_cmd: cover property (@(posedge clock) disable iff (!rst_n) cmd_fire_q && in_frame);
   c_full: cover property (@(posedge clock) disable iff (!rst_n) !fifo_in_ready);
endmodule : hsw_decoder

// [hsw_host_model.sv]
// Host microcontroller model acting as SPI mode 0 master
`timescale 1ns/10ps
module hsw_host_model (
   input wire logic clock,
   output logic spi_sck,
   output logic spi_mosi,
   output logic spi_ss_n
);
   localparam int half_period = 4;

   // Idle link: clock stands low, select high
   initial
   begin
      spi_sck = 1'b0;
      spi_mosi = 1'b0;
      spi_ss_n = 1'b1;
   end

   // Let a number of system clock edges pass
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
   endtask : idle

   // Data changes while sck is low and is sampled on the rise; no return line is read
   task automatic shift_byte(input logic [7:0] value);
      for (int i = 7; i >= 0; i--)
      begin
         spi_mosi <= value[i];
         idle(half_period);
         spi_sck <= 1'b1;
         idle(half_period);
         spi_sck <= 1'b0;
      end
   endtask : shift_byte

   // One transaction under a single select, bytes back to back
   task automatic send_frame(input logic [7:0] bytes [$]);
      @(posedge clock);
      spi_ss_n <= 1'b0;
      idle(half_period);
      foreach (bytes[k])
         shift_byte(bytes[k]);
      idle(half_period);
      spi_ss_n <= 1'b1;
      spi_mosi <= ~spi_mosi; // Released line shows no stale value
      idle(2 * half_period);
   endtask : send_frame
endmodule : hsw_host_model

// [hsw_decoder_tb_top.sv]
// Self-checking testbench for the host serial write and power command decoder
`timescale 1ns/10ps
module hsw_decoder_tb_top;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic wr_ready = 1'b1;
   logic spi_sck;
   logic spi_mosi;
   logic spi_ss_n;
   logic [21:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_valid;
   logic wr_in_cmd_buffer;
   logic wr_to_register;
   logic wr_to_rom;
   logic overflow;
   logic core_clock_en;
   logic pll_on;
   logic osc_on;
   logic regulator_on;
   logic ext_ref_sel;
   logic pll_high_freq;
   logic core_reset;
   logic [31:0] identity_word;
   logic [32:0] words [$];
   int n_mismatch = 0;
   int n_checks = 0;
   int rst_len = 0;
   int rst_run = 0;

   // 50 MHz system clock
   always #10 clock = ~clock;

   hsw_host_model i_hsw_host_model (
      .clock(clock),
      .spi_sck(spi_sck),
      .spi_mosi(spi_mosi),
      .spi_ss_n(spi_ss_n)
   );

   hsw_decoder i_hsw_decoder (
      .clock(clock), .rst_n(rst_n),
      .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_ss_n(spi_ss_n),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_in_cmd_buffer(wr_in_cmd_buffer), .wr_to_register(wr_to_register),
      .wr_to_rom(wr_to_rom), .overflow(overflow), .core_clock_en(core_clock_en),
      .pll_on(pll_on), .osc_on(osc_on), .regulator_on(regulator_on),
      .ext_ref_sel(ext_ref_sel), .pll_high_freq(pll_high_freq),
      .core_reset(core_reset), .identity_word(identity_word)
   );

   // Write sink capture and core reset pulse length measurement
   always @(posedge clock)
   begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
         words.push_back({wr_to_rom, wr_to_register, wr_in_cmd_buffer, wr_addr, wr_data});
      if (core_reset === 1'b1)
         rst_run++;
      else if (rst_run != 0)
      begin
         rst_len = rst_run;
         rst_run = 0;
      end
   end

   task automatic close_out();
      if (n_mismatch == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Bounded wait for captured write words
   task automatic wait_words(input int n);
      for (int i = 0; i < 400 && words.size() < n; i++)
         @(posedge clock);
   endtask : wait_words

   task automatic test_reset();
      check(33'({wr_valid, overflow, core_clock_en, pll_on, osc_on, regulator_on,
                 ext_ref_sel, pll_high_freq, core_reset}), 33'h0_0000_003a);
      check(33'(identity_word), 33'({hsw_pkg::chip_revision, hsw_pkg::chip_identity}));
   endtask : test_reset

   // Burst write; expected address and region flags worked out per byte
   task automatic test_write(input logic [21:0] base, input int n);
      logic [7:0] bytes [$];
      logic [21:0] a;
      logic [2:0] f;
      words.delete();
      bytes.push_back({hsw_pkg::prefix_write, base[21:16]});
      bytes.push_back(base[15:8]);
      bytes.push_back(base[7:0]);
      for (int k = 0; k < n; k++)
         bytes.push_back(8'(8'ha0 + k));
      i_hsw_host_model.send_frame(bytes);
      wait_words(n);
      check(33'(words.size()), 33'(n));
      for (int k = 0; k < words.size() && k < n; k++)
      begin
         a = 22'(base + 22'(k));
         f[2] = a >= hsw_pkg::identity_rom_base && a <= hsw_pkg::identity_rom_last;
         f[1] = a >= hsw_pkg::reg_base && a <= hsw_pkg::reg_last;
         f[0] = a >= hsw_pkg::cmd_buffer_base && a <= hsw_pkg::cmd_buffer_last;
         check(words[k], {f, a, 8'(8'ha0 + k)});
      end
   endtask : test_write

   // Sink stalls while a long burst overruns the buffer, then drains it
   task automatic test_fifo();
      logic [7:0] bytes [$];
      words.delete();
      wr_ready <= 1'b0;
      bytes = '{8'h80, 8'h01, 8'h00};
      for (int k = 0; k < 40; k++)
         bytes.push_back(8'(k));
      i_hsw_host_model.send_frame(bytes);
      check(33'(wr_valid), 33'h0_0000_0001);
      check(33'(overflow), 33'h0_0000_0001);
      wr_ready <= 1'b1;
      wait_words(40);
      check(33'(words.size() >= hsw_pkg::fifo_depth), 33'h0_0000_0001);
      for (int k = 0; k < words.size(); k++)
         check(words[k], {3'h0, 22'(22'h00_0100 + k), 8'(k)});
      check(33'({wr_valid, overflow}), 33'h0_0000_0001);
   endtask : test_fifo

   task automatic send_cmd(input logic [7:0] b0, input logic [7:0] b1, input int count);
      logic [7:0] bytes [$];
      bytes = '{b0, b1, 8'h00};
      while (bytes.size() > count)
         void'(bytes.pop_back());
      i_hsw_host_model.send_frame(bytes);
   endtask : send_cmd

   task automatic test_core_reset();
      rst_len = 0;
      send_cmd(8'h68, 8'h00, 3);
      check(33'(rst_len), 33'(hsw_pkg::core_reset_cycles));
   endtask : test_core_reset

   // Every command code except core reset, a bad trailer byte, a cut-short frame and an ignored read frame
   task automatic test_commands();
      logic [7:0] code [11] = '{8'h00, 8'h41, 8'h00, 8'h42, 8'h61, 8'h62, 8'h44, 8'h41,
                                8'h00, 8'h01, 8'h50};
      logic [7:0] tail [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
                                8'h00, 8'h00, 8'h00};
      int cnt [11] = '{3, 3, 3, 3, 3, 3, 3, 3, 2, 3, 3};
      logic [5:0] exp [11] = '{6'h3d, 6'h1d, 6'h3d, 6'h05, 6'h04, 6'h05, 6'h07, 6'h07,
                               6'h07, 6'h07, 6'h03};
      for (int i = 0; i < 11; i++)
      begin
         send_cmd(code[i], tail[i], cnt[i]);
         check(33'({core_clock_en, pll_on, osc_on, regulator_on, ext_ref_sel,
                    pll_high_freq}), 33'(exp[i]));
      end
   endtask : test_commands

   // Watchdog against a hung link or sink
   initial
   begin
      repeat (30000) @(posedge clock);
      n_mismatch++;
      close_out();
   end

   // Main sequence
   initial
   begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      repeat (8) @(posedge clock);
      test_reset();
      test_write(22'h10_8ffc, 8);
      test_write(22'h10_257e, 2);
      test_write(22'h0c_0000, 8);
      test_fifo();
      test_core_reset();
      test_commands();
      close_out();
   end
endmodule : hsw_decoder_tb_top
